// [core/atcsp_timer.sv]
// Notes on behaviour
// R1: async writes land in per-register holding regs, copied after two osc edges.
// R2: async status register shows one busy bit per holding register.
// R3: software waits for a register's busy bit before rewriting it.
// R4: processor clock must exceed four times the oscillator frequency.
// R5: pending counter or compare write suppresses compare match detection.
// R6: software waits for busy clear before power-save or noise-reduction sleep.
// R7: wake logic re-arms only after one osc cycle following a wake-up.
// R8: oscillator runs in every sleep mode except power-down and standby.
// R9: software reinitialises all timer registers after power-down or standby.
// R10: wake request issues on the timer clock after the wake condition.
// R11: processor stalls four cycles after a timer wake-up.
// R12: counter reads come from a shadow refreshed on each rising osc edge.
// R13: software writes compare or control, waits busy, then reads counter.
// R14: async flags pass three processor cycles; output pin uses timer clock.
// R15: source defaults to I/O clock; async select moves to osc pins.
// R16: software sets external clock enable when an external clock is used.
// R17: software follows the documented order when switching clock source.
// R18: prescaler offers stop, undivided, and divide by 8 to 1024.
// R19: writing prescaler reset bit clears the prescaler phase.
// R20: force strobe in non-PWM acts on pin only, reads zero.
// R21: software writes force bit as zero in PWM modes.
// R22: waveform field bits 6 and 3 pick normal, phase PWM, CLEAR_ON_MATCH_MODE, fast PWM.
// R23: compare updates immediately or at top; overflow at MAX or BOTTOM.
// R24: clock select 000 stops, 001 undivided, then 8 through 1024.
// R25: busy sets on async write, clears when destination loads.
// R26: non-PWM output mode 00 off, 01 toggle, 10 clear, 11 set.
// R27: synchronous mode writes land directly and busy stays clear.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module atcsp_timer #(
    parameter int PRESCALE_BITS = atcsp_pkg::PRESCALE_WIDTH
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_in_pin,
    input  wire logic [2:0]  sleep_mode,
    output logic             osc_enable,
    output logic             ext_clk_buffer_enable,
    output logic             osc_port_detach,
    output logic             compare_output_pin,
    output logic             overflow_flag,
    output logic             compare_match_flag,
    output logic             wake_request,
    output logic             cpu_stall
);
    import atcsp_pkg::*;

    logic        osc_prev;
    logic        async_clock_select;
    logic        ext_clock_input_enable;
    logic [7:0]  timer_control_a;
    logic [7:0]  counter_value;
    logic [7:0]  counter_shadow;
    logic [7:0]  compare_buf;
    logic [7:0]  compare_value_a;
    logic        count_down;
    logic        match_block;
    logic [7:0]  hold [HOLD_COUNT];
    logic [1:0]  edge_cnt [HOLD_COUNT];
    logic [2:0]  busy;
    logic [1:0]  flag_pipe [FLAG_SYNC_CYCLES];
    logic        wake_pending;
    logic        wake_armed;
    logic [2:0]  stall_cnt;

    // bus decode
    wire apb_access = psel & penable & ~pready;
    wire apb_wr     = apb_access & pwrite;
    wire sel_ctl    = (paddr == ADDR_CONTROL_A);
    wire sel_cnt    = (paddr == ADDR_COUNTER);
    wire sel_cmp    = (paddr == ADDR_COMPARE);
    wire sel_ast    = (paddr == ADDR_ASYNC_STATUS);
    wire sel_gtc    = (paddr == ADDR_GENERAL_CTRL);
    wire sel_flg    = (paddr == ADDR_FLAGS);
    wire mapped     = sel_ctl | sel_cnt | sel_cmp | sel_ast | sel_gtc | sel_flg;
    wire [7:0] wbyte = pwdata[7:0];

    // clock source: I/O clock by default, else osc pin edges [R15]
    wire osc_rise = osc_in_pin & ~osc_prev;
    wire src_tick = async_clock_select ? osc_rise : 1'b1;
    wire timer_tick;

    wire [2:0] reg_wr   = {apb_wr & sel_cnt, apb_wr & sel_cmp, apb_wr & sel_ctl};
    wire [2:0] hold_wr  = reg_wr & {3{async_clock_select}};
    wire [2:0] land;

    // one holding register per destination, so writes never disturb each other
    genvar gi;
    generate
        for (gi = 0; gi < HOLD_COUNT; gi++)
        begin : g_hold
            assign land[gi] = busy[gi] & osc_rise & ~hold_wr[gi] &
                              (edge_cnt[gi] == XFER_EDGES - 2'd1); // [R1]
            always_ff @(posedge clk)
            begin
                if (!rst_n || !async_clock_select) // [R27]
                begin
                    hold[gi]     <= 8'h00;
                    busy[gi]     <= 1'b0;
                    edge_cnt[gi] <= 2'h0;
                end
                else if (hold_wr[gi])
                begin
                    hold[gi]     <= wbyte; // [R1]
                    busy[gi]     <= 1'b1; // [R25]
                    edge_cnt[gi] <= 2'h0;
                end
                else if (busy[gi] && osc_rise)
                begin
                    busy[gi]     <= ~land[gi]; // [R25]
                    edge_cnt[gi] <= edge_cnt[gi] + 2'd1;
                end
            end
        end
    endgenerate

    // synchronous mode bypasses the holding registers [R27]
    wire       ctl_load = land[HOLD_CONTROL] | (reg_wr[HOLD_CONTROL] & ~async_clock_select);
    wire       cmp_load = land[HOLD_COMPARE] | (reg_wr[HOLD_COMPARE] & ~async_clock_select);
    wire       cnt_load = land[HOLD_COUNTER] | (reg_wr[HOLD_COUNTER] & ~async_clock_select);
    wire [7:0] ctl_data = land[HOLD_CONTROL] ? hold[HOLD_CONTROL] : wbyte;
    wire [7:0] cmp_data = land[HOLD_COMPARE] ? hold[HOLD_COMPARE] : wbyte;
    wire [7:0] cnt_data = land[HOLD_COUNTER] ? hold[HOLD_COUNTER] : wbyte;

    // mode decode [R22]
    wire atcsp_wave_type wave = atcsp_wave_type'({timer_control_a[CTL_WGM1_BIT],
                                                  timer_control_a[CTL_WGM0_BIT]});
    wire       pwm      = timer_control_a[CTL_WGM0_BIT];
    wire [1:0] com      = timer_control_a[CTL_COM_LSB +: 2];
    wire [7:0] top      = (wave == MODE_CTC) ? compare_value_a : COUNT_MAX; // [R22]
    wire       at_max   = (counter_value == COUNT_MAX);
    wire       at_top   = (counter_value == top);

    atcsp_prescaler #(
        .WIDTH (PRESCALE_BITS)
    ) u_prescaler (
        .clk        (clk),
        .rst_n      (rst_n),
        .src_tick   (src_tick),
        .clear      (apb_wr & sel_gtc & wbyte[GTC_PSR_BIT]), // [R19]
        .select     (timer_control_a[CTL_CS_LSB +: 3]),
        .timer_tick (timer_tick)
    );

    // no match while a counter or compare write is in flight [R5]
    wire match_ev = timer_tick & (counter_value == compare_value_a) & ~match_block &
                    ~busy[HOLD_COMPARE] & ~busy[HOLD_COUNTER];
    wire ovf_ev   = timer_tick & ((wave == MODE_PC_PWM) ? (count_down &&
                    counter_value == COUNT_BOTTOM) : at_max); // [R23]
    wire force_ev = ctl_load & ctl_data[CTL_FORCE_BIT] & ~ctl_data[CTL_WGM0_BIT]; // [R20]

    logic [7:0] next_counter;
    logic       next_down;
    always_comb
    begin
        next_counter = counter_value;
        next_down    = count_down;
        if (cnt_load)
        begin
            next_counter = cnt_data;
        end
        else if (timer_tick)
        begin
            unique case (wave)
                MODE_NORMAL, MODE_FAST_PWM: next_counter = counter_value + 8'd1;
                MODE_CTC: next_counter = at_top ? COUNT_BOTTOM : counter_value + 8'd1;
                MODE_PC_PWM:
                begin
                    if (!count_down && at_max)
                    begin
                        next_down    = 1'b1;
                        next_counter = COUNT_MAX - 8'd1;
                    end
                    else if (count_down && counter_value == COUNT_BOTTOM)
                    begin
                        next_down    = 1'b0;
                        next_counter = COUNT_BOTTOM + 8'd1;
                    end
                    else
                    begin
                        next_counter = count_down ? counter_value - 8'd1
                                                  : counter_value + 8'd1;
                    end
                end
            endcase
        end
    end

    // output pin acts on the timer clock, not resynchronised [R14]
    logic next_pin;
    always_comb
    begin
        next_pin = compare_output_pin;
        if (force_ev)
        begin
            unique case (ctl_data[CTL_COM_LSB +: 2])
                2'h0: next_pin = compare_output_pin;
                2'h1: next_pin = ~compare_output_pin;
                2'h2: next_pin = 1'b0;
                2'h3: next_pin = 1'b1;
            endcase
        end
        else if (!pwm && match_ev)
        begin
            unique case (com)
                2'h0: next_pin = compare_output_pin;
                2'h1: next_pin = ~compare_output_pin; // [R26]
                2'h2: next_pin = 1'b0; // [R26]
                2'h3: next_pin = 1'b1; // [R26]
            endcase
        end
        else if (com[1] && wave == MODE_FAST_PWM && timer_tick && at_max)
        begin
            next_pin = ~com[0]; // top action wins over a match at top
        end
        else if (com[1] && wave == MODE_FAST_PWM && match_ev)
        begin
            next_pin = com[0];
        end
        else if (com[1] && wave == MODE_PC_PWM && match_ev)
        begin
            next_pin = com[0] ^ count_down;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            osc_prev           <= 1'b0;
            timer_control_a    <= CONTROL_A_RESET;
            counter_value      <= COUNTER_RESET;
            compare_buf        <= COMPARE_RESET;
            compare_value_a    <= COMPARE_RESET;
            count_down         <= 1'b0;
            match_block        <= 1'b0;
            compare_output_pin <= 1'b0;
        end
        else
        begin
            osc_prev        <= osc_in_pin;
            counter_value   <= next_counter;
            count_down      <= next_down;
            compare_output_pin <= next_pin;
            // a counter write also blocks the match on the next tick
            match_block     <= cnt_load | (match_block & ~timer_tick);
            if (ctl_load)
            begin
                timer_control_a <= {1'b0, ctl_data[6:0]}; // force bit reads zero [R20]
            end
            if (cmp_load)
            begin
                compare_buf <= cmp_data;
            end
            // immediate in normal and CLEAR_ON_MATCH_MODE, at top in PWM [R23]
            if (cmp_load && !pwm)
            begin
                compare_value_a <= cmp_data;
            end
            else if (pwm && timer_tick && at_max)
            begin
                compare_value_a <= compare_buf;
            end
        end
    end

    // flags cross with a fixed three-cycle delay after the timer tick [R14]
    generate
        for (gi = 0; gi < FLAG_SYNC_CYCLES; gi++)
        begin : g_flag_pipe
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    flag_pipe[gi] <= 2'h0;
                end
                else if (gi == 0)
                begin
                    flag_pipe[gi] <= {match_ev, ovf_ev} & {2{async_clock_select}};
                end
                else
                begin
                    flag_pipe[gi] <= flag_pipe[(gi > 0) ? gi - 1 : 0];
                end
            end
        end
    endgenerate

    wire [1:0] flag_set = async_clock_select ? flag_pipe[FLAG_SYNC_CYCLES-1]
                                             : {match_ev, ovf_ev};
    wire [1:0] flag_clr = {2{apb_wr & sel_flg}} & {wbyte[FLG_CMP_BIT], wbyte[FLG_OVF_BIT]};

    // wake-up path from power-save and noise reduction
    wire sleeping   = (sleep_mode == SLEEP_POWER_SAVE) | (sleep_mode == SLEEP_NOISE_RED);
    wire deep_sleep = (sleep_mode == SLEEP_POWER_DOWN) | (sleep_mode == SLEEP_STANDBY);
    wire wake_fire  = wake_pending & osc_rise; // [R10]
    wire [2:0] next_stall = wake_fire ? WAKE_STALL_CYCLES :
                            (stall_cnt != 3'h0) ? stall_cnt - 3'd1 : 3'h0;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            overflow_flag      <= 1'b0;
            compare_match_flag <= 1'b0;
            wake_pending       <= 1'b0;
            wake_armed         <= 1'b1;
            wake_request       <= 1'b0;
            stall_cnt          <= 3'h0;
            cpu_stall          <= 1'b0;
        end
        else
        begin
            // a set in the clearing cycle is kept
            overflow_flag      <= flag_set[0] | (overflow_flag & ~flag_clr[0]);
            compare_match_flag <= flag_set[1] | (compare_match_flag & ~flag_clr[1]);
            if (wake_fire)
            begin
                wake_pending <= 1'b0;
                wake_armed   <= 1'b0;
            end
            else
            begin
                wake_pending <= wake_pending | (async_clock_select & sleeping &
                                wake_armed & (match_ev | ovf_ev)); // [R10]
                // re-arm only after a full osc cycle has passed [R7]
                wake_armed   <= wake_armed | osc_rise;
            end
            wake_request <= wake_fire;
            stall_cnt    <= next_stall;
            cpu_stall    <= (next_stall != 3'h0); // [R11]
        end
    end

    // shadow refreshed on each rising osc edge, stale right after wake [R12]
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            counter_shadow        <= COUNTER_RESET;
            async_clock_select    <= 1'b0; // [R15]
            ext_clock_input_enable <= 1'b0;
            osc_enable            <= 1'b0;
            ext_clk_buffer_enable <= 1'b0;
            osc_port_detach       <= 1'b0;
        end
        else
        begin
            if (!async_clock_select || osc_rise)
            begin
                counter_shadow <= counter_value; // [R12]
            end
            if (apb_wr && sel_ast)
            begin
                async_clock_select     <= wbyte[AST_ASYNC_BIT]; // [R15]
                ext_clock_input_enable <= wbyte[AST_EXT_CLOCK_INPUT_ENABLE_BIT];
            end
            // crystal only runs while the external buffer is off [R8]
            osc_enable            <= async_clock_select & ~ext_clock_input_enable & ~deep_sleep;
            ext_clk_buffer_enable <= async_clock_select & ext_clock_input_enable & ~deep_sleep;
            osc_port_detach       <= async_clock_select; // [R15]
        end
    end

    // read mux; force bit and prescaler reset always read zero
    wire [7:0] ast_value = {3'h0, ext_clock_input_enable, async_clock_select, busy}; // [R2]
    wire [7:0] rd_value  = sel_ctl ? timer_control_a :
                           sel_cnt ? counter_shadow :
                           sel_cmp ? compare_buf :
                           sel_ast ? ast_value :
                           sel_flg ? {6'h00, compare_match_flag, overflow_flag} : 8'h00;

    // one wait state: answer on the second access cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= apb_access;
            pslverr <= apb_access & ~mapped;
            prdata  <= (apb_access && !pwrite) ? {24'h00_0000, rd_value} : 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// [core/atcsp_pkg.sv]
package atcsp_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CONTROL_A     = 8'hb0;
    localparam logic [7:0] ADDR_COUNTER       = 8'hb4;
    localparam logic [7:0] ADDR_COMPARE       = 8'hb8;
    localparam logic [7:0] ADDR_ASYNC_STATUS  = 8'hbc;
    localparam logic [7:0] ADDR_GENERAL_CTRL  = 8'hc0;
    localparam logic [7:0] ADDR_FLAGS         = 8'hc4;

    // reset values
    localparam logic [7:0] CONTROL_A_RESET    = 8'h00;
    localparam logic [7:0] COUNTER_RESET      = 8'h00;
    localparam logic [7:0] COMPARE_RESET      = 8'h00;

    // timer_control_a fields
    localparam int CTL_FORCE_BIT  = 7;
    localparam int CTL_WGM0_BIT   = 6;
    localparam int CTL_COM_LSB    = 4;
    localparam int CTL_WGM1_BIT   = 3;
    localparam int CTL_CS_LSB     = 0;

    // async_status_register fields
    localparam int AST_EXT_CLOCK_INPUT_ENABLE_BIT  = 4;
    localparam int AST_ASYNC_BIT  = 3;

    // general_timer_control and flag register fields
    localparam int GTC_PSR_BIT    = 1;
    localparam int FLG_OVF_BIT    = 0;
    localparam int FLG_CMP_BIT    = 1;

    // holding register slots, equal to their busy bit positions
    localparam int HOLD_CONTROL   = 0;
    localparam int HOLD_COMPARE   = 1;
    localparam int HOLD_COUNTER   = 2;
    localparam int HOLD_COUNT     = 3;

    // timing counts
    localparam logic [1:0] XFER_EDGES        = 2'd2;
    localparam int         FLAG_SYNC_CYCLES  = 3;
    localparam logic [2:0] WAKE_STALL_CYCLES = 3'd4;
    localparam int         PRESCALE_WIDTH    = 10;

    localparam logic [7:0] COUNT_MAX    = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    // sleep mode codes from the power manager
    localparam logic [2:0] SLEEP_AWAKE       = 3'h0;
    localparam logic [2:0] SLEEP_IDLE        = 3'h1;
    localparam logic [2:0] SLEEP_NOISE_RED   = 3'h2;
    localparam logic [2:0] SLEEP_POWER_DOWN  = 3'h3;
    localparam logic [2:0] SLEEP_POWER_SAVE  = 3'h4;
    localparam logic [2:0] SLEEP_STANDBY     = 3'h5;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_PC_PWM,
        MODE_CTC,
        MODE_FAST_PWM
    } atcsp_wave_type;

endpackage

// [core/atcsp_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module atcsp_prescaler #(
    parameter int WIDTH = 10
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       src_tick,
    input  wire logic       clear,
    input  wire logic [2:0] select,
    output logic            timer_tick
);
    import atcsp_pkg::*;

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] mask;

    function automatic logic [WIDTH-1:0] tap_mask(input logic [2:0] sel);
        logic [9:0] m;
        m = 10'h000;
        unique case (sel)
            3'h0: m = 10'h000;
            3'h1: m = 10'h000;
            3'h2: m = 10'h007;
            3'h3: m = 10'h01f;
            3'h4: m = 10'h03f;
            3'h5: m = 10'h07f;
            3'h6: m = 10'h0ff;
            3'h7: m = 10'h3ff;
        endcase
        return WIDTH'(m);
    endfunction

    // stop, undivided, then 8..1024 [R18] [R24]
    assign mask       = tap_mask(select);
    assign timer_tick = src_tick & (select != 3'h0) & ((count & mask) == mask);

    always_ff @(posedge clk)
    begin
        if (!rst_n || clear)
        begin
            count <= '0; // known phase after a reset strobe [R19]
        end
        else if (src_tick)
        begin
            count <= count + WIDTH'(1);
        end
    end

endmodule
`default_nettype wire

// [dv/atcsp_timer_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module atcsp_timer_properties #(
    parameter int PRESCALE_BITS = 10
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        osc_in_pin,
    input wire logic [2:0]  sleep_mode,
    input wire logic        osc_enable,
    input wire logic        ext_clk_buffer_enable,
    input wire logic        osc_port_detach,
    input wire logic        compare_output_pin,
    input wire logic        overflow_flag,
    input wire logic        compare_match_flag,
    input wire logic        wake_request,
    input wire logic        cpu_stall
);
    import atcsp_pkg::*;
    wire rd_done  = psel && penable && pready && !pwrite;
    wire wr_taken = psel && penable && !pready && pwrite;
    wire deep     = sleep_mode == SLEEP_POWER_DOWN || sleep_mode == SLEEP_STANDBY;
    wire sel_bit  = pwdata[AST_ASYNC_BIT];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_STALL_LEN: assert property (wake_request |-> cpu_stall [*4] ##1 !cpu_stall)
        else $error("stall length wrong");
    AST_WAKE_PULSE: assert property (wake_request |=> !wake_request)
        else $error("wake pulse too long");
    // two cycles asked so a registered sleep decode is not flagged
    AST_OSC_DEEP: assert property (deep [*2] |-> !osc_enable && !ext_clk_buffer_enable)
        else $error("clock running in deep sleep");
    AST_SRC_MUTEX: assert property (!(osc_enable && ext_clk_buffer_enable))
        else $error("crystal and buffer both on");
    AST_SRC_ASYNC: assert property (osc_enable || ext_clk_buffer_enable |-> osc_port_detach)
        else $error("source on without detach");
    AST_FORCE_RD: assert property (rd_done && paddr == ADDR_CONTROL_A |-> !prdata[7])
        else $error("force bit read as one");
    AST_BUSY_SYNC: assert property (rd_done && paddr == ADDR_ASYNC_STATUS
        && !prdata[AST_ASYNC_BIT] |-> prdata[2:0] == 3'h0)
        else $error("busy set in sync mode");
    AST_DETACH_WR: assert property (wr_taken && paddr == ADDR_ASYNC_STATUS
        |-> ##2 osc_port_detach == $past(sel_bit, 2))
        else $error("detach not following select");
    COV_WAKE: cover property (wake_request);
    COV_SLVERR: cover property (rd_done && pslverr);
    COV_EXT: cover property (ext_clk_buffer_enable);
endmodule
bind atcsp_timer atcsp_timer_properties #(.PRESCALE_BITS(PRESCALE_BITS))
    atcsp_timer_properties_inst (.*);
`default_nettype wire

// [dv/atcsp_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module atcsp_osc_model (
    input  wire logic        run,
    input  wire logic [31:0] half_ps,
    output logic             osc_in_pin
);
    // odd picosecond half period keeps edges off the bus clock edges
    always
    begin
        if (run === 1'b1)
            #(half_ps / 1000.0) osc_in_pin = ~osc_in_pin;
        else
        begin
            osc_in_pin = 1'b0;
            @(run);
        end
    end
endmodule
`default_nettype wire

// [dv/async_timer_clock_sync_prescaler_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module async_timer_clock_sync_prescaler_tb_top;
    import atcsp_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, osc_in_pin;
    logic        osc_enable, ext_clk_buffer_enable, osc_port_detach, compare_output_pin;
    logic        overflow_flag, compare_match_flag, wake_request, cpu_stall;
    logic [2:0]  sleep_mode;
    logic [7:0]  paddr, v;
    logic [31:0] pwdata, prdata, rd, half_ps;
    logic [32:0] notes[$];
    int          fails, n_tests, n, divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    atcsp_timer #(.PRESCALE_BITS(10)) atcsp_timer_inst (.*);
    atcsp_osc_model atcsp_osc_model_inst (.run(osc_enable | ext_clk_buffer_enable),
        .half_ps(half_ps), .osc_in_pin(osc_in_pin));
    task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 20)
        begin
            k++;
            @(posedge clk);
        end
        if (k == 20)
            fails++;
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rdx(input logic [7:0] a, input logic [32:0] e);
        notes.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // a rewrite before the holding register drains is not allowed
    task automatic wait_idle();
        rd = 32'h7;
        for (n = 0; n < 100 && rd[2:0] !== 3'h0; n++)
            apb(1'b0, ADDR_ASYNC_STATUS, 32'h0);
        chk("busy_clear", 1'b1, n < 100);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk)
        if (pready === 1'b1 && pwrite === 1'b0 && notes.size() > 0)
            chk("read", notes.pop_front(), {pslverr, prdata});
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        fails++;
        summarize();
    end
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
        sleep_mode = SLEEP_AWAKE;
        half_ps = 533337;
        n = $urandom(80);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdx(ADDR_CONTROL_A, {25'h0, CONTROL_A_RESET});
        rdx(ADDR_COUNTER, {25'h0, COUNTER_RESET});
        rdx(8'ha0, {1'b1, 32'h0});
        chk("detach", 1'b0, osc_port_detach);
        $display("reset test done");
        v = $urandom;
        wr(ADDR_COMPARE, v);
        rdx(ADDR_COMPARE, {25'h0, v});
        wr(ADDR_CONTROL_A, {2'b10, v[5:0]});
        rdx(ADDR_CONTROL_A, {27'h0, v[5:0]});
        rdx(ADDR_ASYNC_STATUS, 33'h0);
        wr(ADDR_CONTROL_A, 8'h00);
        wr(ADDR_FLAGS, 8'h03);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_CONTROL_A, {2'b10, (i < 2) ? 2'(3 - i) : 2'd1, 4'h8});
            chk("pin", i % 2 == 0, compare_output_pin);
        end
        rdx(ADDR_FLAGS, 33'h0);
        $display("force test done");
        for (int c = 1; c < 8; c++)
        begin
            wr(ADDR_CONTROL_A, 8'h00);
            wr(ADDR_FLAGS, 8'h01);
            wr(ADDR_COUNTER, 8'hff);
            wr(ADDR_GENERAL_CTRL, 8'h02);
            wr(ADDR_CONTROL_A, 8'(c) | {1'b0, c % 3 == 2, 2'b0, c % 3 > 0, 3'b0});
            for (n = 0; n < 1100 && overflow_flag !== 1'b1; n++)
                @(posedge clk);
            chk("ovf_time", 1'b1, n >= divs[c] - 10 && n <= divs[c] + 3);
        end
        $display("prescaler test done");
        wr(ADDR_CONTROL_A, 8'h00);
        wr(ADDR_ASYNC_STATUS, 8'h08);
        chk("async_on", 1'b1, osc_port_detach & osc_enable);
        v = $urandom;
        wr(ADDR_COMPARE, v);
        wr(ADDR_COUNTER, ~v);
        rdx(ADDR_ASYNC_STATUS, 33'h0e);
        wait_idle();
        repeat (25) @(posedge clk);
        rdx(ADDR_COMPARE, {25'h0, v});
        rdx(ADDR_COUNTER, {25'h0, ~v});
        $display("async test done");
        wr(ADDR_COUNTER, 8'hf0);
        wr(ADDR_CONTROL_A, 8'h01);
        wr(ADDR_FLAGS, 8'h03);
        wait_idle();
        sleep_mode <= SLEEP_POWER_SAVE;
        for (n = 0; n < 400 && wake_request !== 1'b1; n++)
            @(posedge clk);
        chk("wake", 1'b1, wake_request);
        chk("flag", 1'b1, overflow_flag | compare_match_flag);
        sleep_mode <= SLEEP_AWAKE;
        repeat (25) @(posedge clk);
        sleep_mode <= SLEEP_POWER_DOWN;
        repeat (3) @(posedge clk);
        chk("osc_off", 1'b0, osc_enable);
        sleep_mode <= SLEEP_IDLE;
        repeat (3) @(posedge clk);
        chk("osc_idle", 1'b1, osc_enable);
        sleep_mode <= SLEEP_AWAKE;
        $display("sleep test done");
        half_ps = 1733337;
        wr(ADDR_ASYNC_STATUS, 8'h18);
        chk("ext", 2'b10, {ext_clk_buffer_enable, osc_enable});
        wr(ADDR_COMPARE, ~v);
        wait_idle();
        rdx(ADDR_COMPARE, {25'h0, ~v});
        wr(ADDR_ASYNC_STATUS, 8'h00);
        rdx(ADDR_ASYNC_STATUS, 33'h0);
        $display("ext clock test done");
        summarize();
    end
endmodule
`default_nettype wire
